// File: dac_regs_pkg.sv
// constants of the converter code, pin switch and reference control registers
// Notes on behaviour
// - code is high byte over low nibble
// - code registers reset zero, low nibble reads zero
// - two independent converter channels, own registers
// - switch bit 7 links converter one
// - switch bit 6 links converter two
// - pins zero to four: bit 0 reads zero
// - amp one status read-only, zero when disabled
// - status shows amp one output state whenever amp one is enabled
// - reference register gaps read zero, fields reset
// - amplifier modes come from switch control
// - mode field: off-hiz, on, off-grounded
// - reference select: internal, supply, floating
// - amp one mode bit selects calibration
package dac_regs_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned PIN_A_LAST = 4;

  // byte addresses
  localparam logic [7:0] OFF_ONE_LOW  = 8'h00;
  localparam logic [7:0] OFF_ONE_HIGH = 8'h04;
  localparam logic [7:0] OFF_ONE_MODE = 8'h08;
  localparam logic [7:0] OFF_TWO_LOW  = 8'h0C;
  localparam logic [7:0] OFF_TWO_HIGH = 8'h10;
  localparam logic [7:0] OFF_TWO_MODE = 8'h14;
  localparam logic [7:0] OFF_REF_CTRL = 8'h18;
  localparam logic [7:0] OFF_AMP_CTRL = 8'h1C;
  localparam logic [7:0] OFF_PIN_BASE = 8'h20;

  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] PIN_A_MASK  = 8'hFE;
  localparam logic [7:0] PIN_B_MASK  = 8'hFF;
  localparam logic [7:0] REF_WR_MASK = 8'h13;

  localparam int unsigned CONV_ONE_BIT = 7;
  localparam int unsigned CONV_TWO_BIT = 6;
  localparam int unsigned STATUS_BIT   = 7;
  localparam int unsigned REF_EN_BIT   = 4;
  localparam int unsigned CAL_MODE_BIT = 7;
  localparam int unsigned AMP_EN_BIT   = 5;

  typedef enum logic [1:0] {
    MODE_OFF_HIZ = 2'b00,
    MODE_ON      = 2'b01,
    MODE_OFF_GND = 2'b10,
    MODE_ON_ALT  = 2'b11
  } dac_mode_t;

  localparam logic [1:0] REF_SEL_SUPPLY = 2'b10;
  localparam logic [1:0] REF_SEL_FLOAT  = 2'b11;

endpackage

// File: dac_channel.sv
// one converter channel: code register pair and mode field
`timescale 1ns/100ps
module dac_channel
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic        wr_mode,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  low_value,
  output logic      [7:0]  high_value,
  output logic      [1:0]  mode,
  output logic      [11:0] code
);
  import dac_regs_pkg::*;

  typedef struct packed {
    logic [3:0]  low;
    logic [7:0]  high;
    logic [1:0]  mode;
    logic [11:0] code;
  } chan_t;

  chan_t cur;
  chan_t next_cur;

  always_comb
  begin
    next_cur = cur;
    if (wr_low)
      next_cur.low = wdata[7:4];
    if (wr_mode)
      next_cur.mode = wdata[1:0];
    // converter sees nothing until the high byte lands
    if (wr_high)
    begin
      next_cur.high = wdata;
      next_cur.code = {wdata, cur.low};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign low_value  = {cur.low, 4'h0};
  assign high_value = cur.high;
  assign mode       = cur.mode;
  assign code       = cur.code;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  code_apply_a: assert property (wr_high |=> code == {high_value, $past(low_value[7:4])})
    else $error("code not applied from high write");
  code_hold_a: assert property (!wr_high |=> $stable(code))
    else $error("code changed without high write");
  low_zero_a: assert property (low_value[3:0] == 4'h0)
    else $error("unimplemented low bits not zero");
endmodule

// File: dac_code_and_pin_switch_regs.sv
// apb register bank for two converters, pin switches and reference control
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
module dac_code_and_pin_switch_regs
(
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [dac_regs_pkg::ADDR_W-1:0]        paddr,
  input  wire logic [dac_regs_pkg::DATA_W-1:0]        pwdata,
  input  wire logic [3:0]                             pstrb,
  output logic      [dac_regs_pkg::DATA_W-1:0]        prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic                                   amp_one_output,
  output logic      [11:0]                            dac_one_code,
  output logic      [11:0]                            dac_two_code,
  output logic                                        dac_one_enable,
  output logic                                        dac_two_enable,
  output logic                                        dac_one_grounded,
  output logic                                        dac_two_grounded,
  output logic                                        reference_generator_enable,
  output logic      [1:0]                             conv_reference_select,
  output logic                                        internal_reference_on,
  output logic                                        dac_ref_from_internal,
  output logic                                        dac_ref_from_supply,
  output logic                                        dac_ref_floating,
  output logic                                        amp_one_enable,
  output logic                                        amp_one_calibration_mode,
  output logic      [7:0]                             amp_one_control,
  output logic      [dac_regs_pkg::NUM_PINS-1:0]      conv_one_to_pin_switch,
  output logic      [dac_regs_pkg::NUM_PINS-1:0]      conv_two_to_pin_switch,
  output logic      [dac_regs_pkg::NUM_PINS*6-1:0]    pin_other_switches
);
  import dac_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0]                  ref_ctrl;
    logic [7:0]                  amp_ctrl;
    logic [NUM_PINS-1:0][7:0]    pins;
    logic                        sync1;
    logic                        sync2;
    logic [DATA_W-1:0]           rdata;
    logic                        err;
  } regs_t;

  regs_t cur;
  regs_t next_cur;

  logic        wr;
  logic        setup;
  logic        pin_hit;
  logic [2:0]  pin_idx;
  logic        amp_one_digital_status;
  logic [7:0]  ref_read;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic [7:0]  one_low;
  logic [7:0]  one_high;
  logic [7:0]  two_low;
  logic [7:0]  two_high;
  logic [1:0]  one_mode;
  logic [1:0]  two_mode;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // only byte lane 0 carries register bits
  assign wr      = psel && penable && pwrite && pstrb[0];
  assign setup   = psel && !penable;
  assign pin_hit = (paddr[7:5] == OFF_PIN_BASE[7:5]) && (paddr[1:0] == 2'b00);
  assign pin_idx = paddr[4:2];

  ////////////////////////////////////////////////////////////////////////////
  // converter channels

  dac_channel u_dac_one
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_low     (wr && (paddr == OFF_ONE_LOW)),
    .wr_high    (wr && (paddr == OFF_ONE_HIGH)),
    .wr_mode    (wr && (paddr == OFF_ONE_MODE)),
    .wdata      (pwdata[7:0]),
    .low_value  (one_low),
    .high_value (one_high),
    .mode       (one_mode),
    .code       (dac_one_code)
  );

  dac_channel u_dac_two
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_low     (wr && (paddr == OFF_TWO_LOW)),
    .wr_high    (wr && (paddr == OFF_TWO_HIGH)),
    .wr_mode    (wr && (paddr == OFF_TWO_MODE)),
    .wdata      (pwdata[7:0]),
    .low_value  (two_low),
    .high_value (two_high),
    .mode       (two_mode),
    .code       (dac_two_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // amplifier status

  // disabled amplifier forces its status low whatever the comparator does
  assign amp_one_digital_status = cur.amp_ctrl[AMP_EN_BIT] && cur.sync2;

  always_comb
  begin
    ref_read = cur.ref_ctrl;
    ref_read[STATUS_BIT] = amp_one_digital_status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb
  begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (paddr)
      OFF_ONE_LOW:  rd_byte = one_low;
      OFF_ONE_HIGH: rd_byte = one_high;
      OFF_ONE_MODE: rd_byte = {6'h00, one_mode};
      OFF_TWO_LOW:  rd_byte = two_low;
      OFF_TWO_HIGH: rd_byte = two_high;
      OFF_TWO_MODE: rd_byte = {6'h00, two_mode};
      OFF_REF_CTRL: rd_byte = ref_read;
      OFF_AMP_CTRL: rd_byte = cur.amp_ctrl;
      default:
      begin
        if (pin_hit)
          rd_byte = cur.pins[pin_idx];
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_cur = cur;
    // comparator is analog and asynchronous to pclk
    next_cur.sync1 = amp_one_output;
    next_cur.sync2 = cur.sync1;
    // read data and error are captured in setup so access phase needs no wait
    if (setup)
    begin
      next_cur.rdata = {24'h000000, rd_byte};
      next_cur.err = !rd_hit;
    end
    if (wr && (paddr == OFF_REF_CTRL))
      next_cur.ref_ctrl = pwdata[7:0] & REF_WR_MASK;
    if (wr && (paddr == OFF_AMP_CTRL))
      next_cur.amp_ctrl = pwdata[7:0];
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (wr && pin_hit && (pin_idx == 3'(i)))
        next_cur.pins[i] = pwdata[7:0] & ((i <= PIN_A_LAST) ? PIN_A_MASK : PIN_B_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur <= '0;
    else
      cur <= next_cur;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata  = cur.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && cur.err;

  assign dac_one_enable   = one_mode[0];
  assign dac_two_enable   = two_mode[0];
  assign dac_one_grounded = (one_mode == MODE_OFF_GND);
  assign dac_two_grounded = (two_mode == MODE_OFF_GND);

  assign reference_generator_enable = cur.ref_ctrl[REF_EN_BIT];
  assign conv_reference_select      = cur.ref_ctrl[1:0];
  assign internal_reference_on      = cur.ref_ctrl[REF_EN_BIT] && !cur.ref_ctrl[1];
  assign dac_ref_from_internal      = !cur.ref_ctrl[1];
  assign dac_ref_from_supply        = (cur.ref_ctrl[1:0] == REF_SEL_SUPPLY);
  assign dac_ref_floating           = (cur.ref_ctrl[1:0] == REF_SEL_FLOAT);

  // calibration bit also steers the amplifier's mode switches
  assign amp_one_enable           = cur.amp_ctrl[AMP_EN_BIT];
  assign amp_one_calibration_mode = cur.amp_ctrl[CAL_MODE_BIT];
  assign amp_one_control          = cur.amp_ctrl;

  // no interlock: both converters may drive one pin if software asks
  generate
    for (genvar p = 0; p < NUM_PINS; p++)
    begin : g_pin
      assign conv_one_to_pin_switch[p] = cur.pins[p][CONV_ONE_BIT];
      assign conv_two_to_pin_switch[p] = cur.pins[p][CONV_TWO_BIT];
      assign pin_other_switches[p*6 +: 6] = cur.pins[p][5:0];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  conv_one_switch_a: assert property (wr && pin_hit |=>
      conv_one_to_pin_switch[$past(pin_idx)] == $past(pwdata[7]))
    else $error("converter one switch not updated");
  conv_two_switch_a: assert property (wr && pin_hit |=>
      conv_two_to_pin_switch[$past(pin_idx)] == $past(pwdata[6]))
    else $error("converter two switch not updated");
  pin_bit_zero_a: assert property (pin_other_switches[0] == 1'b0 &&
      pin_other_switches[24] == 1'b0)
    else $error("pin group a bit 0 not zero");
  status_gate_a: assert property (!amp_one_enable |-> !amp_one_digital_status)
    else $error("status set while amplifier disabled");
  status_follow_a: assert property ((amp_one_calibration_mode && amp_one_enable) [*3] |->
      amp_one_digital_status == $past(amp_one_output, 2))
    else $error("status does not follow amplifier output");
  ref_gaps_a: assert property (psel && penable && !pwrite && paddr == OFF_REF_CTRL |->
      prdata[6:5] == 2'b00 && prdata[3:2] == 2'b00)
    else $error("reference register gaps not zero");
  mode_decode_a: assert property (dac_one_grounded |-> !dac_one_enable &&
      one_mode == MODE_OFF_GND)
    else $error("grounded converter also enabled");
  ref_select_a: assert property (wr && paddr == OFF_REF_CTRL && pwdata[1:0] == REF_SEL_FLOAT
      |=> dac_ref_floating && !dac_ref_from_internal && !dac_ref_from_supply)
    else $error("reference select decode wrong");
  low_no_apply_a: assert property (wr && paddr == OFF_ONE_LOW |=> $stable(dac_one_code))
    else $error("low write disturbed converter code");

  cover_code_two_c: cover property (wr && paddr == OFF_TWO_LOW ##[1:4] wr && paddr == OFF_TWO_HIGH);
  cover_short_c: cover property (conv_one_to_pin_switch[5] && conv_two_to_pin_switch[5]);
  cover_status_c: cover property (amp_one_calibration_mode && amp_one_digital_status);
  cover_error_c: cover property (pslverr);
endmodule

// File: test_dac_code_and_pin_switch_regs.sv
// self-checking bench for the converter code, pin switch and reference register bank
`timescale 1ns/100ps
module test_dac_code_and_pin_switch_regs;
  import dac_regs_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic        amp_one_output = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, dac_one_enable, dac_two_enable, dac_one_grounded;
  logic        dac_two_grounded, reference_generator_enable, internal_reference_on;
  logic        dac_ref_from_internal, dac_ref_from_supply, dac_ref_floating;
  logic        amp_one_enable, amp_one_calibration_mode;
  logic [11:0] dac_one_code, dac_two_code;
  logic [1:0]  conv_reference_select;
  logic [7:0]  amp_one_control, sw1, sw2;
  logic [7:0]  conv_one_to_pin_switch, conv_two_to_pin_switch;
  logic [47:0] pin_other_switches, oth;
  logic [7:0]  mreg [0:15];
  logic [11:0] mcode [0:1];
  logic [15:0] seed = 16'h0031;
  int          err_count = 0;
  int          n_checks = 0;

  dac_code_and_pin_switch_regs u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .amp_one_output(amp_one_output), .dac_one_code(dac_one_code),
    .dac_two_code(dac_two_code), .dac_one_enable(dac_one_enable),
    .dac_two_enable(dac_two_enable), .dac_one_grounded(dac_one_grounded),
    .dac_two_grounded(dac_two_grounded),
    .reference_generator_enable(reference_generator_enable),
    .conv_reference_select(conv_reference_select),
    .internal_reference_on(internal_reference_on),
    .dac_ref_from_internal(dac_ref_from_internal), .dac_ref_from_supply(dac_ref_from_supply),
    .dac_ref_floating(dac_ref_floating), .amp_one_enable(amp_one_enable),
    .amp_one_calibration_mode(amp_one_calibration_mode), .amp_one_control(amp_one_control),
    .conv_one_to_pin_switch(conv_one_to_pin_switch),
    .conv_two_to_pin_switch(conv_two_to_pin_switch), .pin_other_switches(pin_other_switches)
  );

  initial
  begin
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  // reserved low bits and gaps are masked so reads can be predicted
  function automatic logic [7:0] wmask(input logic [7:0] a);
    if (a[1:0] != 2'b00 || a > 8'h3C)
      return 8'h00;
    case (a)
      OFF_ONE_LOW, OFF_TWO_LOW:   return 8'hF0;
      OFF_ONE_MODE, OFF_TWO_MODE: return 8'h03;
      OFF_REF_CTRL:               return REF_WR_MASK;
      default:                    return (a >= OFF_PIN_BASE && a <= 8'h30) ? PIN_A_MASK : 8'hFF;
    endcase
  endfunction

  task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] d,
                      input logic [3:0] s);
    logic [31:0] rd, exp;
    logic        err, ok;
    ok = (a[1:0] == 2'b00 && a <= 8'h3C);
    exp = ok ? {24'h0, mreg[a[5:2]]} : 32'h0;
    if (a == OFF_REF_CTRL)
      exp[7] = mreg[7][5] & amp_one_output;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= {seed, seed[15:8], d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung access
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", err, !ok);
    if (!wr)
      chk("prdata", rd, exp);
    if (wr && ok && s[0])
    begin
      mreg[a[5:2]] = d & wmask(a);
      if (a == OFF_ONE_HIGH)
        mcode[0] = {mreg[1], mreg[0][7:4]};
      if (a == OFF_TWO_HIGH)
        mcode[1] = {mreg[4], mreg[3][7:4]};
    end
  endtask

  task automatic chk_out;
    repeat (2) @(negedge pclk);
    for (int p = 0; p < 8; p++)
    begin
      sw1[p] = mreg[8 + p][7];
      sw2[p] = mreg[8 + p][6];
      oth[p * 6 +: 6] = mreg[8 + p][5:0];
    end
    chk("iref", internal_reference_on, mreg[6][4] & !mreg[6][1]);
    chk("ampc", amp_one_control, mreg[7]);
    chk("other_lo", pin_other_switches[23:0], oth[23:0]);
    chk("other_hi", pin_other_switches[47:24], oth[47:24]);
    chk("code1", dac_one_code, mcode[0]);
    chk("code2", dac_two_code, mcode[1]);
    chk("en", {dac_two_enable, dac_one_enable}, {mreg[5][0], mreg[2][0]});
    chk("gnd", {dac_two_grounded, dac_one_grounded},
        {mreg[5][1:0] == 2'b10, mreg[2][1:0] == 2'b10});
    chk("ref", {reference_generator_enable, conv_reference_select}, {mreg[6][4], mreg[6][1:0]});
    chk("src", {dac_ref_from_internal, dac_ref_from_supply, dac_ref_floating},
        {!mreg[6][1], mreg[6][1:0] == 2'b10, mreg[6][1:0] == 2'b11});
    chk("amp", {amp_one_enable, amp_one_calibration_mode}, {mreg[7][5], mreg[7][7]});
    chk("sw1", conv_one_to_pin_switch, sw1);
    chk("sw2", conv_two_to_pin_switch, sw2);
  endtask

  // also used at the end of the run, so a second reset is seen to clear everything
  task automatic reset_and_scan;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++)
      mreg[i] = 8'h00;
    mcode[0] = 12'h000;
    mcode[1] = 12'h000;
    for (int a = 0; a < 16; a++)
      xfer(8'(a * 4), 1'b0, 8'h00, 4'hF);
    chk_out();
    $display("test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] l, h, r;
    reset_and_scan();
    for (int ch = 0; ch < 2; ch++)
      for (int k = 0; k < 5; k++)
      begin
        l = rnd();
        h = rnd();
        if (k == 0)
          {h, l} = 16'hFFFF;
        if (k == 1)
          {h, l} = 16'h0000;
        if (k != 3)
          xfer(ch ? OFF_TWO_LOW : OFF_ONE_LOW, 1'b1, l, 4'hF);
        chk_out();
        xfer(ch ? OFF_TWO_HIGH : OFF_ONE_HIGH, 1'b1, h, 4'hF);
        chk_out();
        xfer(ch ? OFF_TWO_LOW : OFF_ONE_LOW, 1'b0, 8'h00, 4'hF);
      end
    $display("test codes done");
    for (int m = 0; m < 8; m++)
    begin
      r = rnd();
      xfer(m[2] ? OFF_TWO_MODE : OFF_ONE_MODE, 1'b1, {r[7:2], m[1:0]}, 4'hF);
      xfer(OFF_REF_CTRL, 1'b1, {r[7:2], m[1:0]}, 4'hF);
      chk_out();
      xfer(OFF_REF_CTRL, 1'b0, 8'h00, 4'hF);
    end
    $display("test modes done");
    for (int p = 0; p < 8; p++)
    begin
      r = rnd();
      xfer(8'(OFF_PIN_BASE + p * 4), 1'b1, (p == 0) ? 8'hFF : r, 4'hF);
    end
    for (int p = 0; p < 8; p++)
      xfer(8'(OFF_PIN_BASE + p * 4), 1'b0, 8'h00, 4'hF);
    chk_out();
    $display("test pins done");
    for (int k = 0; k < 8; k++)
    begin
      @(posedge pclk);
      amp_one_output <= k[0];
      xfer(OFF_AMP_CTRL, 1'b1, {k[2], 1'b0, k[1], 5'h00}, 4'hF);
      xfer(OFF_REF_CTRL, 1'b1, 8'hFF, 4'hF);
      repeat (4) @(posedge pclk);
      xfer(OFF_REF_CTRL, 1'b0, 8'h00, 4'hF);
      chk_out();
    end
    $display("test status done");
    xfer(8'h40, 1'b1, 8'hAA, 4'hF);
    xfer(8'h05, 1'b1, 8'hAA, 4'hF);
    xfer(8'h01, 1'b0, 8'h00, 4'hF);
    xfer(8'hFC, 1'b0, 8'h00, 4'hF);
    xfer(OFF_ONE_HIGH, 1'b1, 8'h5A, 4'h0);
    xfer(OFF_ONE_HIGH, 1'b0, 8'h00, 4'hF);
    chk_out();
    $display("test refusals done");
    reset_and_scan();
    tally_and_finish();
  end

  initial
  begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule
